//--- rtl/sic_defines.vh
// Constants for the serial interface configuration block
// Summary of operation
// RULE1: Register 0x00 reads as a mirror, bits 7, 6 and 5 always equal bits 0, 1 and 2.
// RULE2: The controller writes register 0x00 with the mirrored pattern in both nibbles.
// RULE3: Address direction bit 2 steps streaming addresses down when 0 and up when 1.
// RULE4: Bit order bit 1 shifts data bytes least significant bit first when 1, else MSB first.
// RULE5: Writing 1 to bit 0 resets the device except register 0x00 and the serial state machine.
// RULE6: The soft reset bit clears itself once the internal soft reset is over.
// RULE7: Single-instruction bit 7 of register 0x01 limits each instruction to one data byte.
// RULE8: With single-instruction clear, data bytes stream to stepped addresses while select is low.
// RULE9: With single-instruction set and select low, the state machine waits for a new instruction.
// RULE10: With single-instruction set, the controller sends a fresh address phase before each byte.
// RULE11: An instruction is a 16-bit address phase, read flag first, then 15 address bits, then bytes.
// RULE12: Select falling starts an instruction, bits are taken on clock rises, select rising ends it.
// RULE13: A read drives the data line after the last address bit and releases it when deselected.
// RULE14: Select rising resets the state machine unless single-instruction and stalling are both set.
`ifndef SIC_DEFINES_VH
`define SIC_DEFINES_VH

// ==========================================================
// Register map
`define SIC_ADDR_CFG_A 15'h0000
`define SIC_ADDR_CFG_B 15'h0001

// ==========================================================
// Field positions
`define SIC_A_SOFT_RESET 0
`define SIC_A_LSB_FIRST 1
`define SIC_A_ASCEND 2
`define SIC_B_SINGLE 7
`define SIC_B_STALL 6
`define SIC_B_READBACK 5
`define SIC_RW_BIT 15

// ==========================================================
// Reset values and counts
`define SIC_CFG_A_RST 3'h0
`define SIC_CFG_B_RST 3'h0
`define SIC_ADDR_BITS_LAST 4'hf
`define SIC_DATA_BITS_LAST 4'h7
`define SIC_SOFT_RST_CYC 5'h10
`define SIC_SYNC_INIT 3'h1

`endif

//--- rtl/sic_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module sic_sync #(
  parameter W = 3,
  parameter [W-1:0] INIT = {W{1'b0}}
)(
  input wire clk_i,
  input wire rst_n_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] level_o
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1)
    begin : bit_sync
      always @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          stage1[g] <= INIT[g];
          stage2[g] <= INIT[g];
          stage3[g] <= INIT[g];
          level_o[g] <= INIT[g];
        end
        else
        begin
          stage1[g] <= async_i[g];
          stage2[g] <= stage1[g];
          stage3[g] <= stage2[g];
          // Accept a change only when the late stages agree
          if (stage2[g] == stage3[g])
          begin
            level_o[g] <= stage3[g];
          end
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

//--- rtl/sic_core.v
// Three-wire serial slave with interface configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "sic_defines.vh"

module sic_core (
  input wire clk_i,
  input wire rst_n_i,
  input wire cs_n_i,
  input wire sclk_i,
  input wire sdio_i,
  output reg sdio_o,
  output reg sdio_oe_n_o,
  output wire soft_reset_o,
  output wire lsb_first_o,
  output wire addr_ascend_o,
  output wire single_instr_o,
  output reg [14:0] reg_addr_o,
  output reg [7:0] reg_wdata_o,
  output reg reg_we_o,
  output reg reg_re_o,
  input wire [7:0] reg_rdata_i
);

  // ==========================================================
  // States
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ADDR = 3'b010;
  localparam [2:0] ST_DATA = 3'b100;

  // ==========================================================
  // Pin synchronisers
  wire sdio_f;
  wire sclk_f;
  wire cs_n_f;

  sic_sync #(
    .W(3),
    .INIT(`SIC_SYNC_INIT)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({sdio_i, sclk_i, cs_n_i}),
    .level_o({sdio_f, sclk_f, cs_n_f})
  );

  reg sclk_q;
  reg cs_n_q;
  wire sclk_rise = sclk_f & ~sclk_q;
  wire cs_fall = ~cs_n_f & cs_n_q;
  wire cs_rise = cs_n_f & ~cs_n_q;

  // ==========================================================
  // State
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [14:0] shift_in;
  reg [7:0] out_sh;
  reg is_read;
  reg [4:0] soft_cnt;
  reg cfg_ascend;
  reg cfg_lsb_first;
  reg [2:0] cfg_b;
  reg addr_step;

  wire soft_busy = (soft_cnt != 5'h00);
  wire [7:0] cfg_a_val = {soft_busy, cfg_lsb_first, cfg_ascend, 2'b00,
                          cfg_ascend, cfg_lsb_first, soft_busy}; // RULE1
  wire [7:0] cfg_b_val = {cfg_b, 5'h00};
  wire single = cfg_b[2];
  wire stall = cfg_b[1];
  wire [7:0] in_byte = {shift_in[6:0], sdio_f};
  wire [14:0] next_addr = cfg_ascend ? reg_addr_o + 15'h0001 : reg_addr_o - 15'h0001; // RULE3

  assign soft_reset_o = soft_busy; // RULE5
  assign lsb_first_o = cfg_lsb_first;
  assign addr_ascend_o = cfg_ascend;
  assign single_instr_o = single;

  // ==========================================================
  // Helpers
  function [7:0] order_byte;
    input [7:0] b;
    input lsb;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        order_byte[i] = lsb ? b[7 - i] : b[i];
      end
    end
  endfunction

  function [7:0] read_mux;
    input [14:0] a;
    input [7:0] va;
    input [7:0] vb;
    input [7:0] ext;
    begin
      if (a == `SIC_ADDR_CFG_A)
      begin
        read_mux = va;
      end
      else if (a == `SIC_ADDR_CFG_B)
      begin
        read_mux = vb;
      end
      else
      begin
        read_mux = ext;
      end
    end
  endfunction

  wire [7:0] rd_byte = order_byte(read_mux(reg_addr_o, cfg_a_val, cfg_b_val, reg_rdata_i),
                                  cfg_lsb_first); // RULE4
  wire [7:0] wr_byte = order_byte(in_byte, cfg_lsb_first); // RULE4

  // ==========================================================
  // Serial engine and registers
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift_in <= 15'h0000;
      out_sh <= 8'h00;
      is_read <= 1'b0;
      sdio_o <= 1'b0;
      sdio_oe_n_o <= 1'b1;
      soft_cnt <= 5'h00;
      cfg_ascend <= 1'b0;
      cfg_lsb_first <= 1'b0;
      cfg_b <= `SIC_CFG_B_RST;
      reg_addr_o <= 15'h0000;
      reg_wdata_o <= 8'h00;
      reg_we_o <= 1'b0;
      reg_re_o <= 1'b0;
      addr_step <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk_f;
      cs_n_q <= cs_n_f;
      reg_we_o <= 1'b0;
      reg_re_o <= 1'b0;
      addr_step <= 1'b0;
      // Step only after the write strobe has used the address
      if (addr_step)
      begin
        reg_addr_o <= next_addr; // RULE3
      end
      if (soft_busy)
      begin
        soft_cnt <= soft_cnt - 5'h01; // RULE6
        cfg_b <= `SIC_CFG_B_RST; // RULE5
      end
      // Load read data one cycle after the address is presented
      if (reg_re_o)
      begin
        out_sh <= rd_byte;
        sdio_o <= rd_byte[7];
        sdio_oe_n_o <= 1'b0; // RULE13
      end
      if (cs_rise)
      begin
        sdio_oe_n_o <= 1'b1; // RULE13
        if (!(single && stall))
        begin
          state <= ST_IDLE; // RULE14
          bit_cnt <= 4'h0;
        end
      end
      else if (cs_fall && state == ST_IDLE)
      begin
        state <= ST_ADDR; // RULE12
        bit_cnt <= 4'h0;
      end
      else if (sclk_rise && !cs_n_f)
      begin
        case (state)
          ST_ADDR:
          begin
            shift_in <= {shift_in[13:0], sdio_f}; // RULE12
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `SIC_ADDR_BITS_LAST)
            begin
              is_read <= shift_in[`SIC_RW_BIT - 1]; // RULE11
              reg_addr_o <= {shift_in[13:0], sdio_f}; // RULE11
              reg_re_o <= shift_in[`SIC_RW_BIT - 1];
              bit_cnt <= 4'h0;
              state <= ST_DATA;
            end
          end
          ST_DATA:
          begin
            shift_in <= {shift_in[13:0], sdio_f};
            bit_cnt <= bit_cnt + 4'h1;
            if (is_read)
            begin
              sdio_o <= out_sh[6];
              out_sh <= {out_sh[6:0], 1'b0};
            end
            if (bit_cnt == `SIC_DATA_BITS_LAST)
            begin
              bit_cnt <= 4'h0;
              if (!is_read)
              begin
                if (reg_addr_o == `SIC_ADDR_CFG_A)
                begin
                  cfg_ascend <= wr_byte[`SIC_A_ASCEND]; // RULE1
                  cfg_lsb_first <= wr_byte[`SIC_A_LSB_FIRST]; // RULE1
                  if (wr_byte[`SIC_A_SOFT_RESET])
                  begin
                    soft_cnt <= `SIC_SOFT_RST_CYC; // RULE5
                  end
                end
                else if (reg_addr_o == `SIC_ADDR_CFG_B)
                begin
                  cfg_b <= wr_byte[`SIC_B_SINGLE:`SIC_B_READBACK];
                end
                else
                begin
                  reg_we_o <= 1'b1;
                  reg_wdata_o <= wr_byte;
                end
              end
              if (single)
              begin
                state <= ST_ADDR; // RULE7 RULE9
                sdio_oe_n_o <= 1'b1;
              end
              else if (is_read)
              begin
                reg_addr_o <= next_addr; // RULE8 RULE3
                reg_re_o <= 1'b1; // RULE8
              end
              else
              begin
                addr_step <= 1'b1; // RULE8
              end
            end
          end
          ST_IDLE:
          begin
            state <= ST_IDLE;
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

//--- verif/sic_core_checker.sv
// Assertion checker for the serial configuration core
`timescale 1ns/1ps
`default_nettype none
module sic_core_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sdio_oe_n_o,
  input wire logic soft_reset_o,
  input wire logic single_instr_o,
  input wire logic [14:0] reg_addr_o,
  input wire logic reg_we_o,
  input wire logic reg_re_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ========
  // Link and strobes
  a_oe_release: assert property (cs_n_i [*8] |-> sdio_oe_n_o)
    else $error("data line driven while deselected");
  a_read_drives: assert property (reg_re_o |-> ##2 !sdio_oe_n_o)
    else $error("read data not driven");
  a_we_pulse: assert property (reg_we_o |=> !reg_we_o)
    else $error("write strobe too long");
  a_re_pulse: assert property (reg_re_o |=> !reg_re_o)
    else $error("read strobe too long");
  a_idle_quiet: assert property (cs_n_i [*8] |-> !(reg_we_o || reg_re_o))
    else $error("strobe while deselected");
  a_we_not_cfg: assert property (reg_we_o |-> reg_addr_o > 15'h0001)
    else $error("config write leaked to bus");
  // ========
  // Soft reset
  a_sr_hold: assert property ($rose(soft_reset_o) |-> soft_reset_o [*8])
    else $error("soft reset too short");
  a_sr_ends: assert property ($rose(soft_reset_o) |-> ##[16:40] !soft_reset_o)
    else $error("soft reset not cleared");
  a_sr_clears_b: assert property (soft_reset_o ##1 soft_reset_o |-> !single_instr_o)
    else $error("config b kept in soft reset");
  cover property (reg_we_o);
  cover property (reg_re_o);
  cover property ($rose(soft_reset_o));
  cover property (single_instr_o && reg_we_o);
endmodule
bind sic_core sic_core_checker chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
  .sdio_oe_n_o(sdio_oe_n_o), .soft_reset_o(soft_reset_o), .single_instr_o(single_instr_o),
  .reg_addr_o(reg_addr_o), .reg_we_o(reg_we_o), .reg_re_o(reg_re_o));
`default_nettype wire

//--- verif/sic_ctrl_model.sv
// Model of the serial controller on the link pins
`timescale 1ns/1ps
`default_nettype none
module sic_ctrl_model (
  input wire logic line_i,
  output var logic cs_n_o,
  output var logic sclk_o,
  output var logic sdio_o
);
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdio_o = 1'b0;
  end
  // ========
  // Select and byte shift, clock idle low
  task sel(input logic v);
    #250 cs_n_o = v;
    sdio_o = ~sdio_o;
    #250;
  endtask
  task sh(input logic [7:0] v, output logic [7:0] r);
    integer i;
    for (i = 7; i >= 0; i = i - 1)
    begin
      sdio_o = v[i];
      #62.5 sclk_o = 1'b1;
      r[i] = line_i;
      #62.5 sclk_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- verif/sic_core_tb.sv
// Self-checking bench for the serial configuration core
`timescale 1ns/1ps
`default_nettype none
module sic_core_tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cs_n, sclk, dq, sdio_o, oe_n, sr, lsbf_o, asc, single, we, re;
  logic [14:0] addr, we_a;
  logic [7:0] wd, we_d, got;
  logic lsbf = 1'b0;
  integer errors = 0;
  integer checks_done = 0;
  integer i;
  logic [23:0] rows [0:9] = '{
    24'h80_0000,
    24'h00_105a,
    24'h80_3095,
    24'h00_0024,
    24'h80_0024,
    24'h00_0066,
    24'h80_0066,
    24'h00_2001,
    24'h80_3194,
    24'h00_0000};
  wire logic line = oe_n ? dq : sdio_o;
  wire logic [7:0] reg_rdata_i = addr[7:0] ^ 8'ha5;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (we)
    begin
      we_a <= addr;
      we_d <= wd;
    end
  sic_core dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sclk_i(sclk), .sdio_i(line),
    .sdio_o(sdio_o), .sdio_oe_n_o(oe_n), .soft_reset_o(sr), .lsb_first_o(lsbf_o),
    .addr_ascend_o(asc), .single_instr_o(single), .reg_addr_o(addr), .reg_wdata_o(wd),
    .reg_we_o(we), .reg_re_o(re), .reg_rdata_i(reg_rdata_i));
  sic_ctrl_model ctl_u (.line_i(line), .cs_n_o(cs_n), .sclk_o(sclk), .sdio_o(dq));
  // ========
  // Tasks
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  function logic [7:0] rev(input logic [7:0] v);
    integer k;
    for (k = 0; k < 8; k = k + 1)
      rev[k] = v[7 - k];
  endfunction
  task hdr(input logic [15:0] h);
    ctl_u.sh(h[15:8], got);
    ctl_u.sh(h[7:0], got);
  endtask
  task dat(input logic [7:0] v);
    ctl_u.sh(lsbf ? rev(v) : v, got);
    if (lsbf)
      got = rev(got);
    #100;
  endtask
  task op(input logic [23:0] r);
    ctl_u.sel(1'b0);
    hdr(r[23:8]);
    dat(r[7:0]);
    ctl_u.sel(1'b1);
    if (r[23])
      chk(got, r[7:0]);
    else if (r[22:8] > 15'h0001)
      chk({we_a[7:0], we_d}, r[15:0]);
    else if (!r[8])
    begin
      lsbf = r[1];
      chk({asc, lsbf_o}, r[2:1]);
    end
  endtask
  task tally_and_finish;
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ========
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    chk({oe_n, sr, lsbf_o, asc, single}, 16'h0010);
    for (i = 0; i < 10; i = i + 1)
      op(rows[i]);
    ctl_u.sel(1'b0);
    hdr(16'h0040);
    dat(8'h11);
    dat(8'h22);
    ctl_u.sel(1'b1);
    chk({we_a[7:0], we_d}, 16'h3f22);
    op(24'h00_0180);
    chk(single, 1'b1);
    ctl_u.sel(1'b0);
    hdr(16'h0050);
    dat(8'h33);
    hdr(16'h0060);
    dat(8'h44);
    ctl_u.sel(1'b1);
    chk({we_a[7:0], we_d}, 16'h6044);
    op(24'h00_01c0);
    ctl_u.sel(1'b0);
    ctl_u.sh(8'h00, got);
    ctl_u.sel(1'b1);
    ctl_u.sel(1'b0);
    ctl_u.sh(8'h70, got);
    dat(8'h55);
    ctl_u.sel(1'b1);
    chk({we_a[7:0], we_d}, 16'h7055);
    op(24'h00_0081);
    chk(sr, 1'b0);
    chk(single, 1'b0);
    op(24'h80_0000);
    op(24'h00_0024);
    @(posedge clk_i);
    #1 rst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    chk({oe_n, sr, lsbf_o, asc, single}, 16'h0010);
    op(24'h80_0000);
    tally_and_finish;
  end
endmodule
`default_nettype wire
